// File: rtl/pcl_pkg.sv
// Purpose: shared constants for the pin-config / led-voltage converter register bank
// Assumes: one 100 MHz clock, registers 8 bits wide
// Notes: offsets, field positions, reset values and timing counts live here
package pcl_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PCL_ADDR_PIN = 8'h20;
  localparam logic [7:0] PCL_ADDR_VOLT = 8'h30;
  localparam logic [7:0] PCL_ADDR_DLY = 8'h31;
  // ----------------------------------------------------------------
  // pin_function_control fields
  // ----------------------------------------------------------------
  localparam int PCL_P1_CTRL = 0;
  localparam int PCL_P1_DIR = 1;
  localparam int PCL_P1_DATA = 2;
  localparam int PCL_P2_CTRL = 3;
  localparam int PCL_P2_DIR = 4;
  localparam int PCL_P2_DATA = 5;
  localparam int PCL_P2_INTEN = 6;
  localparam logic [7:0] PCL_PIN_RST = 8'h00;
  // ----------------------------------------------------------------
  // led_voltage_converter fields
  // ----------------------------------------------------------------
  localparam int PCL_V_MAN = 4;
  localparam int PCL_V_SHDN = 5;
  localparam int PCL_V_EOC = 6;
  localparam logic [3:0] PCL_RES_RST = 4'h0;
  // ----------------------------------------------------------------
  // conversion_start_delay fields
  // ----------------------------------------------------------------
  localparam int PCL_D_NODLY = 5;
  localparam logic [4:0] PCL_DLY_RST = 5'h0F;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PCL_CLK_MHZ = 100;
  localparam int PCL_STEP_US = 250;
  localparam int PCL_STEP_CYC = PCL_STEP_US * PCL_CLK_MHZ;
  // ----------------------------------------------------------------
  // register access commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCL_CMD_IDLE = 2'h0,
    PCL_CMD_WRITE = 2'h1,
    PCL_CMD_READ = 2'h2
  } pcl_cmd_t;
endpackage

// File: rtl/pcl_if.sv
// Purpose: register access path between host controller and device bank
// Assumes: single clock; one access per strobe
// Notes: pins of the device are outside this carrier
`timescale 1ns/1ps
interface pcl_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport dev (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// File: rtl/pcl_delay.sv
// Purpose: start-delay timer for the voltage converter
// Assumes: load pulses once per armed conversion
// Notes: done pulses one cycle when the delay has elapsed
`timescale 1ns/1ps
module pcl_delay #(
  parameter int STEP_CYC = pcl_pkg::PCL_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic bypass,
  input wire logic [4:0] code,
  output logic done
);
  import pcl_pkg::*;
  logic [20:0] cnt_q;
  logic run_q;
  // ------------------------------------------------------------
  // countdown of (code+1) steps, or one cycle when bypassed
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 21'h000000;
      run_q <= 1'b0;
    end else if (load) begin
      run_q <= 1'b1;
      cnt_q <= bypass ? 21'h000000 :
        21'(({16'h0000, code} + 21'h000001) * 21'(STEP_CYC) - 21'h000001);
    end else if (run_q) begin
      if (cnt_q == 21'h000000) run_q <= 1'b0;
      else cnt_q <= cnt_q - 21'h000001;
    end
  end
  assign done = run_q && (cnt_q == 21'h000000);
endmodule

// File: rtl/pcl_dev.sv
// Purpose: device end: pin function, led voltage converter and delay registers
// Assumes: converter analog result arrives as a 4-bit code with a valid pulse
// Notes: conversion timing beyond the start delay is the analog side's
`timescale 1ns/1ps
module pcl_dev #(
  parameter int STEP_CYC = pcl_pkg::PCL_STEP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  pcl_if.dev bus,
  // sync pins
  input wire logic sync_pin_one_in,
  output logic sync_pin_one_out,
  output logic sync_pin_one_oe,
  input wire logic sync_pin_two_in,
  output logic sync_pin_two_out,
  output logic sync_pin_two_oe,
  // sync roles and interrupt source
  output logic rf_sync_input_one,
  output logic rf_sync_input_two,
  input wire logic int_event,
  // converter analog side
  input wire logic flash_start,
  output logic conv_start,
  input wire logic conv_valid,
  input wire logic [3:0] conv_code
);
  import pcl_pkg::*;
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] s1_q, s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
    end else begin
      s1_q <= {sync_pin_two_in, sync_pin_one_in};
      s2_q <= s1_q;
    end
  end
  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  logic wr_pin, wr_volt, wr_dly, rd_volt;
  assign wr_pin = bus.req && bus.wr && (bus.addr == PCL_ADDR_PIN);
  assign wr_volt = bus.req && bus.wr && (bus.addr == PCL_ADDR_VOLT);
  assign wr_dly = bus.req && bus.wr && (bus.addr == PCL_ADDR_DLY);
  assign rd_volt = bus.req && !bus.wr && (bus.addr == PCL_ADDR_VOLT);
  logic [7:0] pin_q;
  logic [7:0] pin_prev_q;
  logic armed_q;
  logic prev_vld_q;
  logic in1_q, in2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= PCL_PIN_RST;
      pin_prev_q <= PCL_PIN_RST;
      armed_q <= 1'b0;
      prev_vld_q <= 1'b0;
      in1_q <= 1'b0;
      in2_q <= 1'b0;
    end else if (wr_pin) begin
      pin_q <= bus.wdata & 8'h7F;
      pin_prev_q <= bus.wdata;
      prev_vld_q <= 1'b1;
      // output drive needs the same value twice; reset value is no first write
      if (armed_q || (prev_vld_q && (bus.wdata == pin_prev_q))) armed_q <= 1'b1;
      in1_q <= s2_q[0];
      in2_q <= s2_q[1];
    end
  end
  // ------------------------------------------------------------
  // pin roles
  // ------------------------------------------------------------
  logic io1, io2, int_mode;
  assign io1 = pin_q[PCL_P1_CTRL];
  assign io2 = pin_q[PCL_P2_CTRL];
  assign int_mode = pin_q[PCL_P2_INTEN] && io2 && pin_q[PCL_P2_DIR];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_pin_one_out <= 1'b0;
      sync_pin_one_oe <= 1'b0;
      sync_pin_two_out <= 1'b0;
      sync_pin_two_oe <= 1'b0;
      rf_sync_input_one <= 1'b0;
      rf_sync_input_two <= 1'b0;
    end else begin
      sync_pin_one_oe <= io1 && pin_q[PCL_P1_DIR] && armed_q;
      sync_pin_one_out <= pin_q[PCL_P1_DATA];
      sync_pin_two_oe <= io2 && pin_q[PCL_P2_DIR] && armed_q;
      // interrupt is active low
      sync_pin_two_out <= int_mode ? !int_event : pin_q[PCL_P2_DATA];
      rf_sync_input_one <= io1 ? 1'b0 : s2_q[0];
      rf_sync_input_two <= io2 ? 1'b0 : s2_q[1];
    end
  end
  // ------------------------------------------------------------
  // converter control
  // ------------------------------------------------------------
  logic man_q, shdn_q, eoc_q, nodly_q, busy_q;
  logic [3:0] res_q;
  logic [4:0] dly_q;
  logic eoc_fall_q, dly_done;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      man_q <= 1'b0;
      shdn_q <= 1'b0;
      dly_q <= PCL_DLY_RST;
      nodly_q <= 1'b0;
    end else begin
      if (wr_volt) begin
        man_q <= bus.wdata[PCL_V_MAN];
        shdn_q <= bus.wdata[PCL_V_SHDN];
      end
      if (wr_dly) begin
        dly_q <= bus.wdata[4:0];
        nodly_q <= bus.wdata[PCL_D_NODLY];
      end
    end
  end
  // flag: completion sets, read clears, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_q <= 1'b0;
      res_q <= PCL_RES_RST;
    end else if (conv_valid && busy_q) begin
      eoc_q <= 1'b1;
      res_q <= conv_code;
    end else if (rd_volt) begin
      eoc_q <= 1'b0;
    end
  end
  // arm delay when flag drops; automatic on flash, manual repeats
  logic trig;
  assign trig = !shdn_q && !busy_q &&
    (flash_start || (man_q && rd_volt && eoc_q));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eoc_fall_q <= 1'b0;
      busy_q <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      eoc_fall_q <= trig;
      conv_start <= dly_done && !shdn_q;
      if (trig) busy_q <= 1'b1;
      else if (conv_valid || shdn_q) busy_q <= 1'b0;
    end
  end
  pcl_delay #(.STEP_CYC(STEP_CYC)) u_dly (
    .clk(clk),
    .rst_n(rst_n),
    .load(eoc_fall_q),
    .bypass(nodly_q),
    .code(dly_q),
    .done(dly_done)
  );
  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= 8'h00;
      bus.ack <= 1'b0;
    end else begin
      bus.ack <= bus.req;
      if (bus.req && !bus.wr) begin
        if (bus.addr == PCL_ADDR_PIN)
          bus.rdata <= {1'b0, pin_q[6], (pin_q[PCL_P2_DIR] ? pin_q[5] : in2_q), pin_q[4:3],
            (pin_q[PCL_P1_DIR] ? pin_q[2] : in1_q), pin_q[1:0]};
        else if (bus.addr == PCL_ADDR_VOLT)
          bus.rdata <= {1'b0, eoc_q, shdn_q, man_q, res_q};
        else if (bus.addr == PCL_ADDR_DLY)
          bus.rdata <= {2'h0, nodly_q, dly_q};
        else
          bus.rdata <= 8'h00;
      end
    end
  end
endmodule

// File: rtl/pcl_host.sv
// Purpose: host end: issues register accesses for the user side
// Assumes: user holds cmd until done
// Notes: pin register writes asked as setup are sent twice
`timescale 1ns/1ps
module pcl_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  pcl_if.host bus,
  // user side
  input wire pcl_pkg::pcl_cmd_t cmd,
  input wire logic setup,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata
);
  import pcl_pkg::*;
  typedef enum logic [3:0] {
    PCL_H_IDLE = 4'b0001,
    PCL_H_REQ = 4'b0010,
    PCL_H_WAIT = 4'b0100,
    PCL_H_GAP = 4'b1000
  } pcl_hst_t;
  pcl_hst_t st_q;
  logic again_q;
  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= PCL_H_IDLE;
      again_q <= 1'b0;
      bus.req <= 1'b0;
      bus.wr <= 1'b0;
      bus.addr <= 8'h00;
      bus.wdata <= 8'h00;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      case (st_q)
        PCL_H_IDLE: begin
          if (cmd != PCL_CMD_IDLE && !done) begin
            bus.req <= 1'b1;
            bus.wr <= (cmd == PCL_CMD_WRITE);
            bus.addr <= addr;
            bus.wdata <= wdata;
            // same value twice for output setup
            again_q <= setup && (cmd == PCL_CMD_WRITE) && (addr == PCL_ADDR_PIN);
            st_q <= PCL_H_REQ;
          end
        end
        PCL_H_REQ: begin
          bus.req <= 1'b0;
          st_q <= PCL_H_WAIT;
        end
        PCL_H_WAIT: begin
          if (bus.ack) begin
            if (again_q) begin
              again_q <= 1'b0;
              st_q <= PCL_H_GAP;
            end else begin
              rdata <= bus.rdata;
              done <= 1'b1;
              st_q <= PCL_H_IDLE;
            end
          end
        end
        // idle cycle keeps repeated writes three cycles apart
        PCL_H_GAP: begin
          bus.req <= 1'b1;
          st_q <= PCL_H_REQ;
        end
        default: st_q <= PCL_H_IDLE;
      endcase
    end
  end
  assign busy = (st_q != PCL_H_IDLE);
endmodule

// File: tb/pcl_props.sv
// Purpose: checks on the register path between host end and device end
// Assumes: one clock, rst_n asynchronous active low
// Notes: delay shadow mirrors host writes to the delay register
`timescale 1ns/1ps
module pcl_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access path
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  import pcl_pkg::*;
  logic [7:0] dly_q;
  logic map_hit;
  assign map_hit = addr == PCL_ADDR_PIN || addr == PCL_ADDR_VOLT || addr == PCL_ADDR_DLY;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_q <= {3'h0, PCL_DLY_RST};
    end else if (req && wr && addr == PCL_ADDR_DLY) begin
      dly_q <= wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_next; req |=> ack; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after req");
  property p_ack_cause; ack |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_gap; req |=> !req [*2]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("requests too close");
  property p_rdata_hold; $changed(rdata) |-> ack && !$past(wr); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved outside a read");
  property p_unmapped; req && !wr && !map_hit |=> rdata == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pin_bit7; req && !wr && addr == PCL_ADDR_PIN |=> !rdata[7]; endproperty
  a_pin_bit7: assert property (p_pin_bit7) else $error("pin bit 7 set");
  property p_dly_read; req && !wr && addr == PCL_ADDR_DLY |=> rdata[5:0] == dly_q[5:0];
  endproperty
  a_dly_read: assert property (p_dly_read) else $error("delay readback wrong");
endmodule

// File: tb/pin_config_and_led_voltage_adc_regs_tb_top.sv
// Purpose: host end and device end joined, driven from user and pin sides
// Assumes: STEP_CYC cut to 4 so delays stay short
// Notes: delay figures judged as differences, fixed latency cancels out
`timescale 1ns/1ps
module pin_config_and_led_voltage_adc_regs_tb_top;
  import pcl_pkg::*;
  localparam int STEP = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcl_cmd_t cmd = PCL_CMD_IDLE;
  logic setup = 1'b0;
  logic [7:0] u_addr = 8'h00;
  logic [7:0] u_wdata = 8'h00;
  logic busy, done, p1_out, p1_oe, p2_out, p2_oe, rf1, rf2, conv_start;
  logic [7:0] u_rdata, rd;
  logic p1_in = 1'b0;
  logic p2_in = 1'b0;
  logic int_ev = 1'b0;
  logic flash = 1'b0;
  logic conv_valid = 1'b0;
  logic [3:0] conv_code = 4'h0;
  int n_mismatch = 0;
  int n_checks = 0;
  int t0, t3;
  // wire level: device drives while its enable is high
  wire logic pin1 = p1_oe ? p1_out : p1_in;
  wire logic pin2 = p2_oe ? p2_out : p2_in;
  pcl_if bus_if (.clk(clk), .rst_n(rst_n));
  pcl_host u_pcl_host (.clk(clk), .rst_n(rst_n), .bus(bus_if.host), .cmd(cmd), .setup(setup),
    .addr(u_addr), .wdata(u_wdata), .busy(busy), .done(done), .rdata(u_rdata));
  pcl_dev #(.STEP_CYC(STEP)) u_pcl_dev (.clk(clk), .rst_n(rst_n), .bus(bus_if.dev),
    .sync_pin_one_in(pin1), .sync_pin_one_out(p1_out), .sync_pin_one_oe(p1_oe),
    .sync_pin_two_in(pin2), .sync_pin_two_out(p2_out), .sync_pin_two_oe(p2_oe),
    .rf_sync_input_one(rf1), .rf_sync_input_two(rf2), .int_event(int_ev),
    .flash_start(flash), .conv_start(conv_start), .conv_valid(conv_valid),
    .conv_code(conv_code));
  pcl_props u_pcl_props (.clk(clk), .rst_n(rst_n), .req(bus_if.req), .wr(bus_if.wr),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata));
  initial forever #5 clk = ~clk;
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  // cmd held until done, as the host end expects
  task automatic acc(input pcl_cmd_t c, input logic s, input logic [7:0] a,
                     input logic [7:0] d);
    @(negedge clk);
    cmd = c;
    setup = s;
    u_addr = a;
    u_wdata = d;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
    chk1("done", 1'b1, done);
    rd = u_rdata;
    cmd = PCL_CMD_IDLE;
    setup = 1'b0;
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    acc(PCL_CMD_WRITE, 1'b0, a, d);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    acc(PCL_CMD_READ, 1'b0, a, 8'h00);
    chk8(what, exp, rd);
  endtask
  // cycles from flash pulse to conversion start, 400 when none comes
  task automatic flash_time(output int cyc);
    @(negedge clk);
    flash = 1'b1;
    @(negedge clk);
    flash = 1'b0;
    for (cyc = 1; cyc < 400 && conv_start !== 1'b1; cyc++) @(negedge clk);
  endtask
  task automatic conv_fin(input logic [3:0] code);
    @(negedge clk);
    conv_valid = 1'b1;
    conv_code = code;
    @(negedge clk);
    conv_valid = 1'b0;
  endtask
  task automatic t_reset();
    rd_chk("pin_rst", PCL_ADDR_PIN, 8'h00);
    rd_chk("volt_rst", PCL_ADDR_VOLT, 8'h00);
    rd_chk("dly_rst", PCL_ADDR_DLY, 8'h0F);
    rd_chk("unmapped", 8'h40, 8'h00);
    p1_in = 1'b1;
    repeat (4) @(negedge clk);
    chk1("rf1_role", 1'b1, rf1);
  endtask
  task automatic t_pin_out();
    wr8(PCL_ADDR_PIN, 8'h38);
    chk1("oe2_single", 1'b0, p2_oe);
    acc(PCL_CMD_WRITE, 1'b1, PCL_ADDR_PIN, 8'hB8);
    chk1("oe2_double", 1'b1, p2_oe);
    chk1("out2_high", 1'b1, p2_out);
    chk1("rf2_gpio", 1'b0, rf2);
    rd_chk("pin_b7", PCL_ADDR_PIN, 8'h3C);
    wr8(PCL_ADDR_PIN, 8'h1F);
    chk1("out2_low", 1'b0, p2_out);
    chk1("oe1_single", 1'b1, p1_oe);
    chk1("out1_high", 1'b1, p1_out);
  endtask
  task automatic t_pin_in();
    wr8(PCL_ADDR_PIN, 8'h01);
    rd_chk("in1_high", PCL_ADDR_PIN, 8'h05);
    p1_in = 1'b0;
    repeat (4) @(negedge clk);
    rd_chk("in1_held", PCL_ADDR_PIN, 8'h05);
    wr8(PCL_ADDR_PIN, 8'h01);
    rd_chk("in1_low", PCL_ADDR_PIN, 8'h01);
  endtask
  task automatic t_int();
    int_ev = 1'b1;
    acc(PCL_CMD_WRITE, 1'b1, PCL_ADDR_PIN, 8'hF8);
    chk1("int_oe", 1'b1, p2_oe);
    chk1("int_act", 1'b0, p2_out);
    int_ev = 1'b0;
    repeat (4) @(negedge clk);
    chk1("int_idle", 1'b1, p2_out);
    int_ev = 1'b1;
    wr8(PCL_ADDR_PIN, 8'hB8);
    chk1("int_off", 1'b1, p2_out);
  endtask
  task automatic t_conv();
    wr8(PCL_ADDR_DLY, 8'h00);
    flash_time(t0);
    conv_fin(4'h9);
    rd_chk("eoc_set", PCL_ADDR_VOLT, 8'h49);
    rd_chk("eoc_clr", PCL_ADDR_VOLT, 8'h09);
    wr8(PCL_ADDR_DLY, 8'h03);
    flash_time(t3);
    chk8("dly_steps", 8'(3 * STEP), 8'(t3 - t0));
    conv_fin(4'hF);
    rd_chk("code_max", PCL_ADDR_VOLT, 8'h4F);
    wr8(PCL_ADDR_DLY, 8'h20);
    flash_time(t3);
    chk1("bypass", 1'b1, t3 < t0);
    conv_fin(4'h1);
    wr8(PCL_ADDR_VOLT, 8'h20);
    flash_time(t3);
    chk1("shutdown", 1'b1, t3 >= 400);
    wr8(PCL_ADDR_VOLT, 8'h10);
    flash_time(t3);
    chk1("auto_in_man", 1'b1, t3 < 400);
    conv_fin(4'h0);
    rd_chk("man_eoc", PCL_ADDR_VOLT, 8'h50);
    for (t3 = 0; t3 < 400 && conv_start !== 1'b1; t3++) @(negedge clk);
    chk1("man_start", 1'b1, t3 < 400);
    conv_fin(4'h2);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100us;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_pin_out();
    t_pin_in();
    t_int();
    t_conv();
    complete_run();
  end
endmodule
